//--- common/addc_pkg.sv
package addc_pkg;
    // ******************************
    // Register offsets
    // ******************************
    localparam logic [7:0] ADDR_PATH_CTRL = 8'h24;
    localparam logic [7:0] ADDR_DEC_CFG   = 8'h25;
    localparam logic [7:0] ADDR_MIX_CFG   = 8'h26;
    localparam logic [7:0] ADDR_IQ_ORDER  = 8'h27;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;
    localparam logic [7:0] ADDR_FREQ_B0   = 8'h2A;
    localparam logic [7:0] ADDR_FREQ_B1   = 8'h2B;
    localparam logic [7:0] ADDR_FREQ_B2   = 8'h2C;
    localparam logic [7:0] ADDR_FREQ_B3   = 8'h2D;
    localparam logic [7:0] REG_RESET      = 8'h00;
    // ******************************
    // Field positions and masks
    // ******************************
    localparam int BIT_FEATURE_EN   = 2;
    localparam int BIT_FILTER_EN    = 1;
    localparam int DEC_LSB          = 4;
    localparam int BIT_REAL_OUT     = 3;
    localparam int BIT_OSC_INVERT   = 0;
    localparam int GAIN_LSB         = 6;
    localparam int BIT_OSC_RELOAD   = 5;
    localparam int BIT_QMIX_EN      = 4;
    localparam int BIT_IQ_SWAP      = 4;
    localparam int BIT_QUAD_DELAY   = 3;
    localparam int BIT_QMIX_INVERT  = 2;
    localparam logic [7:0] MASK_PATH_CTRL = 8'h06;
    localparam logic [7:0] MASK_DEC_CFG   = 8'h79;
    localparam logic [7:0] MASK_MIX_CFG   = 8'hF0;
    localparam logic [7:0] MASK_IQ_ORDER  = 8'h1C;
    localparam logic [2:0] DEC_MAX_CODE   = 3'h5;
    localparam logic [1:0] GAIN_3DB       = 2'h1;
    localparam logic [1:0] GAIN_6DB       = 2'h2;
    // ******************************
    // Widths
    // ******************************
    localparam int SAMPLE_W = 14;
    localparam int OUT_W    = 20;
    localparam int MIX_W    = 16;
    localparam int ACC_W    = 21;
    localparam int FIFO_DEPTH = 8;
    // ******************************
    // Types
    // ******************************
    typedef enum logic [1:0] {
        ST_FIRST  = 2'h0,
        ST_SECOND = 2'h1
    } addc_emit_type;
    typedef struct packed {
        logic             quad;
        logic [OUT_W-1:0] data;
    } addc_word_type;
    localparam int WORD_W = OUT_W + 1;
endpackage

//--- src/addc_top.sv
`timescale 1ns/1ns
// Behaviour
// R1 - Feature path sits in the sample path only when feature enable is one.
// R2 - Feature enable zero routes samples straight out with least latency.
// R3 - Filter enable turns down-conversion filter on for both channels.
// R4 - Ratio code 000 no decimation, 001..101 give 2 to 32, others unused.
// R5 - Real select zero means complex decimation, one means real decimation.
// R6 - Real decimation is low-pass only, no mixing.
// R7 - Software should set oscillator frequency to zero in real mode.
// R8 - Phase invert bit negates the oscillator output phase.
// R9 - Mixer gain adds 0, 3 or 6 dB after the mixer; code 11 unused.
// R10 - Toggling reload bit zeroes oscillator phase and loads new frequency.
// R11 - Quarter-rate mixing enable mixes by Fs/4, complex mode only.
// R12 - Swap bit emits quadrature word before in-phase word.
// R13 - Quad delay bit pairs I[n] with Q[n+1].
// R14 - Quarter-rate invert bit inverts the Fs/4 mixer phase.
// R15 - Frequency word is four bytes, least significant at lowest offset.
// R16 - Real mode forces the four frequency bytes to zero.
// R17 - Output format control only acts with the feature path enabled.
// R18 - Reserved bits are written zero and have no function.

// ******************************
// Output FIFO
// ******************************
module addc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire logic        push = ce_i & in_valid_i & in_ready_o;
    wire logic        pop  = ce_i & out_valid_o & out_ready_i;

    assign full_o      = (cnt_r == (AW+1)'(DEPTH));
    assign empty_o     = (cnt_r == '0);
    assign in_ready_o  = ~full_o;
    assign out_valid_o = ~empty_o;
    assign out_data_o  = mem_r[rp_r];

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            if (push & ~pop) cnt_r <= cnt_r + 1'b1;
            else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

// ******************************
// Digital feature path
// ******************************
module addc_top #(
    parameter int FIFO_DEPTH = addc_pkg::FIFO_DEPTH
) (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          ce_i,
    input  wire logic [7:0]                    addr_i,
    input  wire logic [7:0]                    wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic [7:0]                         rdata_o,
    input  wire logic                          sample_valid_i,
    output logic                               sample_ready_o,
    input  wire logic [addc_pkg::SAMPLE_W-1:0] sample_i,
    output logic                               out_valid_o,
    input  wire logic                          out_ready_i,
    output addc_pkg::addc_word_type            out_word_o
);
    // ******************************
    // Registers
    // ******************************
    logic [7:0]  path_ctrl_r;
    logic [7:0]  dec_cfg_r;
    logic [7:0]  mix_cfg_r;
    logic [7:0]  iq_order_r;
    logic [31:0] freq_r;
    logic [7:0]  rdata_r;

    wire logic feature_path_enable    = path_ctrl_r[addc_pkg::BIT_FEATURE_EN];
    wire logic downconv_filter_enable = path_ctrl_r[addc_pkg::BIT_FILTER_EN];
    wire logic [2:0] dec_code        = dec_cfg_r[addc_pkg::DEC_LSB +: 3];
    wire logic real_mode             = dec_cfg_r[addc_pkg::BIT_REAL_OUT];
    wire logic osc_invert            = dec_cfg_r[addc_pkg::BIT_OSC_INVERT];
    wire logic [1:0] mix_gain_chan_a = mix_cfg_r[addc_pkg::GAIN_LSB +: 2];
    wire logic osc_phase_reload_chan_a = mix_cfg_r[addc_pkg::BIT_OSC_RELOAD];
    wire logic quarter_rate_mix_chan_a = mix_cfg_r[addc_pkg::BIT_QMIX_EN];
    wire logic iq_swap_chan_a        = iq_order_r[addc_pkg::BIT_IQ_SWAP];
    wire logic quad_delay_chan_a     = iq_order_r[addc_pkg::BIT_QUAD_DELAY];
    wire logic quarter_rate_mix_invert_chan_a = iq_order_r[addc_pkg::BIT_QMIX_INVERT];

    wire logic wr_en = ce_i & wr_i;
    wire logic fifo_full;
    wire logic fifo_empty;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            path_ctrl_r <= addc_pkg::REG_RESET;
            dec_cfg_r   <= addc_pkg::REG_RESET;
            mix_cfg_r   <= addc_pkg::REG_RESET;
            iq_order_r  <= addc_pkg::REG_RESET;
        end else if (wr_en) begin
            // Reserved bits are dropped on write [R18]
            case (addr_i)
                addc_pkg::ADDR_PATH_CTRL: path_ctrl_r <= wdata_i & addc_pkg::MASK_PATH_CTRL;
                addc_pkg::ADDR_DEC_CFG:   dec_cfg_r   <= wdata_i & addc_pkg::MASK_DEC_CFG;
                addc_pkg::ADDR_MIX_CFG:   mix_cfg_r   <= wdata_i & addc_pkg::MASK_MIX_CFG;
                addc_pkg::ADDR_IQ_ORDER:  iq_order_r  <= wdata_i & addc_pkg::MASK_IQ_ORDER;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_r <= '0;
        end else if (ce_i) begin
            if (real_mode) begin
                freq_r <= '0; // [R16]
            end else if (wr_i) begin
                case (addr_i) // [R15]
                    addc_pkg::ADDR_FREQ_B0: freq_r[7:0]   <= wdata_i;
                    addc_pkg::ADDR_FREQ_B1: freq_r[15:8]  <= wdata_i;
                    addc_pkg::ADDR_FREQ_B2: freq_r[23:16] <= wdata_i;
                    addc_pkg::ADDR_FREQ_B3: freq_r[31:24] <= wdata_i;
                    default: ;
                endcase
            end
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        case (addr_i)
            addc_pkg::ADDR_PATH_CTRL: rd_mux = path_ctrl_r;
            addc_pkg::ADDR_DEC_CFG:   rd_mux = dec_cfg_r;
            addc_pkg::ADDR_MIX_CFG:   rd_mux = mix_cfg_r;
            addc_pkg::ADDR_IQ_ORDER:  rd_mux = iq_order_r;
            addc_pkg::ADDR_STATUS:    rd_mux = {6'h00, fifo_empty, fifo_full};
            addc_pkg::ADDR_FREQ_B0:   rd_mux = freq_r[7:0];
            addc_pkg::ADDR_FREQ_B1:   rd_mux = freq_r[15:8];
            addc_pkg::ADDR_FREQ_B2:   rd_mux = freq_r[23:16];
            addc_pkg::ADDR_FREQ_B3:   rd_mux = freq_r[31:24];
            default:                  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_r <= 8'h00;
        else if (ce_i) rdata_r <= rd_i ? rd_mux : 8'h00;
    end
    assign rdata_o = rdata_r;

    // ******************************
    // Oscillator
    // ******************************
    logic [31:0] phase_r;
    logic [31:0] freq_act_r;
    logic        reload_prev_r;
    logic [1:0]  qphase_r;
    wire logic   take = ce_i & sample_valid_i & sample_ready_o;
    wire logic   reload_toggle = reload_prev_r ^ osc_phase_reload_chan_a;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r       <= '0;
            freq_act_r    <= '0;
            reload_prev_r <= 1'b0;
            qphase_r      <= 2'h0;
        end else if (ce_i) begin
            reload_prev_r <= osc_phase_reload_chan_a;
            if (reload_toggle) begin
                phase_r    <= '0;      // [R10]
                freq_act_r <= freq_r;  // [R10]
                qphase_r   <= 2'h0;
            end else if (take) begin
                phase_r  <= phase_r + freq_act_r;
                qphase_r <= qphase_r + 2'h1;
            end
        end
    end

    // Coarse cosine table on the top three phase bits
    function automatic logic signed [7:0] cos_lut(input logic [2:0] p);
        case (p)
            3'h0: cos_lut = 8'sh40;
            3'h1: cos_lut = 8'sh2D;
            3'h2: cos_lut = 8'sh00;
            3'h3: cos_lut = -8'sh2D;
            3'h4: cos_lut = -8'sh40;
            3'h5: cos_lut = -8'sh2D;
            3'h6: cos_lut = 8'sh00;
            default: cos_lut = 8'sh2D;
        endcase
    endfunction

    wire logic [2:0] ph3 = phase_r[31:29] ^ {osc_invert, 2'h0}; // [R8]
    wire logic signed [7:0] osc_cos = cos_lut(ph3);
    wire logic signed [7:0] osc_sin = -cos_lut(ph3 + 3'h2);

    // Fs/4 sequence: cos 1,0,-1,0 and sin 0,-1,0,1 [R11] [R14]
    wire logic [1:0] qp = qphase_r ^ {quarter_rate_mix_invert_chan_a, 1'b0};
    wire logic signed [7:0] q_cos = qp[0] ? 8'sh00 : (qp[1] ? -8'sh40 : 8'sh40);
    wire logic signed [7:0] q_sin = qp[0] ? (qp[1] ? 8'sh40 : -8'sh40) : 8'sh00;

    wire logic use_qmix = quarter_rate_mix_chan_a & ~real_mode; // [R11]
    wire logic signed [7:0] lo_i = real_mode ? 8'sh40 : (use_qmix ? q_cos : osc_cos); // [R6]
    wire logic signed [7:0] lo_q = real_mode ? 8'sh00 : (use_qmix ? q_sin : osc_sin); // [R6]

    wire logic signed [21:0] prod_i = $signed(sample_i) * lo_i;
    wire logic signed [21:0] prod_q = $signed(sample_i) * lo_q;
    wire logic signed [addc_pkg::MIX_W-1:0] mix_i = addc_pkg::MIX_W'(prod_i >>> 6);
    wire logic signed [addc_pkg::MIX_W-1:0] mix_q = addc_pkg::MIX_W'(prod_q >>> 6);

    // ******************************
    // Decimating low-pass
    // ******************************
    wire logic dec_valid_code = (dec_code != 3'h0) && (dec_code <= addc_pkg::DEC_MAX_CODE); // [R4]
    wire logic filt_on = feature_path_enable & downconv_filter_enable & dec_valid_code; // [R1] [R3]
    wire logic [4:0] dec_mask = 5'((6'h01 << dec_code) - 6'h01); // [R4]

    logic [4:0] dec_cnt_r;
    logic signed [addc_pkg::ACC_W-1:0] acc_i_r;
    logic signed [addc_pkg::ACC_W-1:0] acc_q_r;
    wire logic dump = filt_on & take & (dec_cnt_r == dec_mask);
    wire logic signed [addc_pkg::ACC_W-1:0] sum_i = acc_i_r + addc_pkg::ACC_W'(mix_i);
    wire logic signed [addc_pkg::ACC_W-1:0] sum_q = acc_q_r + addc_pkg::ACC_W'(mix_q);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_cnt_r <= '0;
            acc_i_r   <= '0;
            acc_q_r   <= '0;
        end else if (ce_i) begin
            if (!filt_on) begin
                dec_cnt_r <= '0;
                acc_i_r   <= '0;
                acc_q_r   <= '0;
            end else if (take) begin
                dec_cnt_r <= dump ? 5'h00 : dec_cnt_r + 5'h01;
                acc_i_r   <= dump ? '0 : sum_i;
                acc_q_r   <= dump ? '0 : sum_q;
            end
        end
    end

    wire logic signed [addc_pkg::ACC_W-1:0] avg_i = sum_i >>> dec_code;
    wire logic signed [addc_pkg::ACC_W-1:0] avg_q = sum_q >>> dec_code;

    // Gain after mixer: 3 dB approx 1.375x, 6 dB is 2x [R9]
    function automatic logic signed [addc_pkg::OUT_W-1:0] apply_gain(
        input logic signed [addc_pkg::ACC_W-1:0] v, input logic [1:0] g);
        logic signed [addc_pkg::OUT_W-1:0] x;
        x = addc_pkg::OUT_W'(v);
        case (g)
            addc_pkg::GAIN_3DB: apply_gain = x + (x >>> 2) + (x >>> 3);
            addc_pkg::GAIN_6DB: apply_gain = x <<< 1;
            default:            apply_gain = x;
        endcase
    endfunction

    wire logic signed [addc_pkg::OUT_W-1:0] gi = apply_gain(avg_i, mix_gain_chan_a);
    wire logic signed [addc_pkg::OUT_W-1:0] gq = apply_gain(avg_q, mix_gain_chan_a);

    // ******************************
    // Word emission
    // ******************************
    addc_pkg::addc_emit_type st_r;
    addc_pkg::addc_emit_type st_nxt;
    logic [addc_pkg::OUT_W-1:0] hold_r;
    logic                       hold_quad_r;
    logic [addc_pkg::OUT_W-1:0] i_prev_r;
    wire logic fifo_ready;

    wire logic [addc_pkg::OUT_W-1:0] raw_word = addc_pkg::OUT_W'($signed(sample_i));
    wire logic [addc_pkg::OUT_W-1:0] i_sel = quad_delay_chan_a ? i_prev_r : gi; // [R13]
    wire logic [addc_pkg::OUT_W-1:0] first_w  = iq_swap_chan_a ? gq : i_sel;   // [R12]
    wire logic [addc_pkg::OUT_W-1:0] second_w = iq_swap_chan_a ? i_sel : gq;   // [R12]
    wire logic complex_out = ~real_mode; // [R5]

    assign sample_ready_o = fifo_ready & (st_r == addc_pkg::ST_FIRST);

    addc_pkg::addc_word_type push_word;
    logic push_valid;
    always_comb begin
        st_nxt     = st_r;
        push_valid = 1'b0;
        push_word  = '{quad: 1'b0, data: raw_word};
        case (st_r)
            addc_pkg::ST_FIRST: begin
                if (!filt_on) begin
                    // Straight route, one word per sample [R2]
                    push_valid = sample_valid_i;
                end else if (dump) begin
                    push_valid = 1'b1;
                    push_word  = '{quad: complex_out & iq_swap_chan_a, data: first_w};
                    if (complex_out) st_nxt = addc_pkg::ST_SECOND;
                end
            end
            addc_pkg::ST_SECOND: begin
                push_valid = 1'b1;
                push_word  = '{quad: hold_quad_r, data: hold_r};
                if (fifo_ready) st_nxt = addc_pkg::ST_FIRST;
            end
            default: st_nxt = addc_pkg::ST_FIRST;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r        <= addc_pkg::ST_FIRST;
            hold_r      <= '0;
            hold_quad_r <= 1'b0;
            i_prev_r    <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            if (dump) begin
                hold_r      <= second_w;
                hold_quad_r <= ~iq_swap_chan_a;
                i_prev_r    <= gi; // [R13]
            end
        end
    end

    addc_fifo #(
        .WIDTH (addc_pkg::WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_word_o),
        .full_o      (fifo_full),
        .empty_o     (fifo_empty)
    );
endmodule

//--- testbench/addc_properties.sv
`timescale 1ns/1ns
module addc_checker #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        sample_valid_i,
    input wire logic        sample_ready_o,
    input wire logic [13:0] sample_i,
    input wire logic        out_valid_o,
    input wire logic        out_ready_i,
    input wire logic [20:0] out_word_o
);
    // ****************
    // Shadow state
    // ****************
    logic [7:0]                 path_r;
    logic [7:0]                 iq_r;
    logic                       real_r;
    logic [addc_pkg::OUT_W-1:0] sext_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            path_r <= 8'h00;
            iq_r   <= 8'h00;
            real_r <= 1'b0;
            sext_r <= '0;
        end else if (ce_i) begin
            sext_r <= addc_pkg::OUT_W'($signed(sample_i));
            if (wr_i && addr_i == addc_pkg::ADDR_PATH_CTRL) begin
                path_r <= wdata_i & addc_pkg::MASK_PATH_CTRL;
            end
            if (wr_i && addr_i == addc_pkg::ADDR_IQ_ORDER) begin
                iq_r <= wdata_i & addc_pkg::MASK_IQ_ORDER;
            end
            if (wr_i && addr_i == addc_pkg::ADDR_DEC_CFG) begin
                real_r <= wdata_i[addc_pkg::BIT_REAL_OUT];
            end
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_read(logic [7:0] a);
        ce_i && rd_i && addr_i == a;
    endsequence
    sequence s_take;
        ce_i && sample_valid_i && sample_ready_o;
    endsequence
    chk_rdata_idle_zero: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    chk_unmapped_read: assert property (s_read(8'h30) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_path_readback: assert property (s_read(addc_pkg::ADDR_PATH_CTRL) |=> rdata_o == $past(path_r))
        else $error("path control readback wrong");
    chk_iq_readback: assert property (s_read(addc_pkg::ADDR_IQ_ORDER) |=> rdata_o == $past(iq_r))
        else $error("order control readback wrong");
    chk_freq_forced_zero: assert property (real_r && $past(real_r) && ce_i && rd_i
        && addr_i == addc_pkg::ADDR_FREQ_B3 |=> rdata_o == 8'h00)
        else $error("frequency byte not zero in real mode");
    chk_bypass_word: assert property ((!path_r[addc_pkg::BIT_FEATURE_EN] && !out_valid_o) ##0 s_take
        |=> out_valid_o && !out_word_o[20] && out_word_o[19:0] == sext_r)
        else $error("bypass word wrong");
    chk_word_holds: assert property (out_valid_o && !out_ready_i && ce_i
        |=> out_valid_o && $stable(out_word_o))
        else $error("output word changed while stalled");
    chk_status_empty: assert property (s_read(addc_pkg::ADDR_STATUS)
        |=> rdata_o[1] != $past(out_valid_o) && rdata_o[7:2] == 6'h00)
        else $error("status empty flag wrong");
endmodule
bind addc_top addc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(sample_i),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_word_o(out_word_o)
);

//--- testbench/addc_host_model.sv
`timescale 1ns/1ns
module addc_host_model (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    stall_i,
    input  wire logic                    slow_i,
    input  wire logic                    valid_i,
    input  wire addc_pkg::addc_word_type word_i,
    output logic                         ready_o
);
    // ****************
    // Capture
    // ****************
    addc_pkg::addc_word_type got_q[$];
    logic                    slow_r = 1'b0;
    assign ready_o = !stall_i && !(slow_i && slow_r);
    always @(posedge ref_clk_i) begin
        slow_r <= !slow_r;
        if (rst_n_i && valid_i && ready_o) begin
            got_q.push_back(word_i);
        end
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic        ce_i;
    logic [7:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        sample_valid_i;
    logic        sample_ready_o;
    logic [13:0] sample_i;
    logic        out_valid_o;
    logic        out_ready_i;
    logic [20:0] out_word_o;
    logic        stall;
    logic        slow;
    int          num_errors;
    int          n_compared;
    int          cycles;
    addc_top #(.FIFO_DEPTH(8)) DUT (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(sample_i),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_word_o(out_word_o)
    );
    addc_host_model host (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .slow_i(slow),
        .valid_i(out_valid_o), .word_i(out_word_o), .ready_o(out_ready_i)
    );
    // ****************
    // Clock and limit
    // ****************
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
        check("rdata", {24'h0, rdata_o}, {24'h0, e});
    endtask
    task automatic push(input logic [13:0] s, input int n);
        int k;
        repeat (n) begin
            @(posedge ref_clk_i);
            sample_i <= s;
            sample_valid_i <= 1'b1;
            k = 0;
            do begin
                @(posedge ref_clk_i);
                k++;
            end while (sample_ready_o !== 1'b1 && k < 100);
            sample_valid_i <= 1'b0;
        end
    endtask
    task automatic get(input logic q, input logic [19:0] d);
        int k;
        addc_pkg::addc_word_type w;
        k = 0;
        while (host.got_q.size() == 0 && k < 200) begin
            @(posedge ref_clk_i);
            k++;
        end
        w = (host.got_q.size() > 0) ? host.got_q.pop_front() : 21'h1FFFFF;
        check("word", {11'h0, w}, {11'h0, q, d});
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        logic [7:0] a[8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
        logic [7:0] m[4] = '{8'h06, 8'h79, 8'hF0, 8'h1C};
        for (int i = 0; i < 8; i++) rd(a[i], 8'h00);
        rd(addc_pkg::ADDR_STATUS, 8'h02);
        rd(8'h30, 8'h00);
        for (int i = 4; i < 8; i++) begin
            wr(a[i], a[i] ^ 8'h5A);
            rd(a[i], a[i] ^ 8'h5A);
        end
        for (int i = 0; i < 4; i++) begin
            wr(a[i], 8'hFF);
            rd(a[i], m[i]);
        end
        for (int i = 4; i < 8; i++) rd(a[i], 8'h00);
        for (int i = 0; i < 4; i++) wr(a[i], 8'h00);
    endtask
    task automatic t_bypass();
        push(14'h0005, 1);
        get(1'b0, 20'h00005);
        push(14'h3FFD, 1);
        get(1'b0, 20'hFFFFD);
        wr(8'h24, 8'h02);
        wr(8'h25, 8'h10);
        push(14'h0006, 1);
        get(1'b0, 20'h00006);
        wr(8'h24, 8'h04);
        push(14'h0007, 1);
        get(1'b0, 20'h00007);
        wr(8'h24, 8'h06);
        wr(8'h25, 8'h60);
        push(14'h0009, 1);
        get(1'b0, 20'h00009);
    endtask
    task automatic t_real();
        for (int k = 1; k < 6; k++) begin
            wr(8'h25, {1'b0, 3'(k), 4'h8});
            push(14'h0003, 1 << k);
            get(1'b0, 20'h00003);
        end
        check("extra", 32'(host.got_q.size()), 32'h0);
        wr(8'h2B, 8'h3C);
        rd(8'h2B, 8'h00);
    endtask
    task automatic t_complex();
        logic [19:0] g[3] = '{20'h00008, 20'h0000B, 20'h00010};
        slow <= 1'b1;
        wr(8'h25, 8'h10);
        for (int i = 0; i < 3; i++) begin
            wr(8'h26, {2'(i), 6'h20});
            push(14'h0008, 2);
            get(1'b0, g[i]);
            get(1'b1, 20'h00000);
        end
        wr(8'h26, 8'h20);
        wr(8'h25, 8'h11);
        push(14'h0008, 2);
        get(1'b0, 20'hFFFF8);
        get(1'b1, 20'h00000);
        wr(8'h25, 8'h10);
        wr(8'h27, 8'h10);
        push(14'h0008, 2);
        get(1'b1, 20'h00000);
        get(1'b0, 20'h00008);
        wr(8'h27, 8'h08);
        push(14'h0010, 2);
        get(1'b0, 20'h00008);
        get(1'b1, 20'h00000);
        wr(8'h27, 8'h00);
        wr(8'h2D, 8'h80);
        push(14'h0008, 2);
        get(1'b0, 20'h00008);
        get(1'b1, 20'h00000);
        wr(8'h26, 8'h00);
        push(14'h0008, 2);
        get(1'b0, 20'h00000);
        get(1'b1, 20'h00000);
        wr(8'h2D, 8'h00);
        wr(8'h26, 8'h20);
        wr(8'h25, 8'h20);
        wr(8'h26, 8'h30);
        push(14'h0008, 4);
        get(1'b0, 20'h00000);
        get(1'b1, 20'h00000);
        slow <= 1'b0;
    endtask
    task automatic t_fifo();
        wr(8'h24, 8'h00);
        wr(8'h26, 8'h00);
        stall <= 1'b1;
        for (int i = 0; i < 8; i++) push(14'(i), 1);
        @(posedge ref_clk_i);
        check("ready", {31'h0, sample_ready_o}, 32'h0);
        rd(addc_pkg::ADDR_STATUS, 8'h01);
        stall <= 1'b0;
        for (int i = 0; i < 8; i++) get(1'b0, 20'(i));
        rd(addc_pkg::ADDR_STATUS, 8'h02);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        sample_valid_i = 1'b0;
        sample_i = '0;
        stall = 1'b0;
        slow = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_bypass();
        t_real();
        t_complex();
        t_fifo();
        conclude();
    end
endmodule
